// [bac_map.svh]
// Register map, field positions, reset values and pin indices for the bus arbiter
`ifndef BAC_MAP_SVH
`define BAC_MAP_SVH
`define BAC_OFF_CTRL 4'h0
`define BAC_OFF_STATUS 4'h4
`define BAC_OFF_CS0_BASE 4'h8
`define BAC_CTRL_BUS_CLEAR_MASK 0
`define BAC_CTRL_LCS 1
`define BAC_CTRL_SAM 2
`define BAC_CTRL_EXTERNAL_MASTER_WAIT 3
`define BAC_CTRL_VGE 4
`define BAC_CTRL_LOW_POWER_ENABLE 5
`define BAC_CTRL_BUS_CLEAR_OUT_USED 6
`define BAC_CTRL_W 7
`define BAC_CTRL_RST 7'h00
`define BAC_CS0_BASE_DIS_RST 16'hc000
`define BAC_CS0_BASE_CORE_RST 16'h0000
`define BAC_ASYNC_WAIT 2'h3
`define BAC_SYNC_WAIT_EXTRA 2'h1
`define BAC_SYNC_WAIT 2'h0
`define BAC_PIN_BR 0
`define BAC_PIN_BG 1
`define BAC_PIN_AS 2
`define BAC_PIN_BERR 3
`define BAC_PIN_HALT 4
`define BAC_PIN_BGACK 5
`define BAC_PIN_BUS_CLEAR_OUT 6
`define BAC_PIN_STRAP 7
`define BAC_NPINS 8
`endif

// [bac_pkg.sv]
// Types shared by the bus arbiter
package bac_pkg;
  typedef enum logic [2:0] {
    BAC_OWN_NONE,
    BAC_OWN_EXT,
    BAC_OWN_SERIAL_DMA,
    BAC_OWN_INDEPENDENT_DMA,
    BAC_OWN_CARD
  } bac_owner_t;
  typedef enum logic [2:0] {
    BAC_ST_IDLE,
    BAC_ST_CORE_REQ,
    BAC_ST_WAIT_FREE,
    BAC_ST_OWNED,
    BAC_ST_DIS_REQ,
    BAC_ST_DIS_WAIT,
    BAC_ST_DIS_OWN
  } bac_state_t;
endpackage : bac_pkg

// [bac_arbiter.sv]
// Bus arbiter with disabled-core peripheral mode and Avalon-MM control registers
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "bac_map.svh"
module bac_arbiter (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_cpu_disable_strap,
  input wire logic i_br_n,
  output logic o_br_n,
  output logic o_br_oe,
  input wire logic i_bg_n,
  output logic o_bg_n,
  output logic o_bg_oe,
  input wire logic i_as_n,
  input wire logic i_berr_n,
  input wire logic i_halt_n,
  input wire logic i_bgack_n,
  output logic o_bgack_n,
  output logic o_bgack_oe,
  input wire logic i_bus_clear_out_n,
  output logic o_bus_clear_out_n,
  output logic o_bus_clear_out_oe,
  output logic o_core_bus_request,
  input wire logic i_core_bus_grant,
  input wire logic i_interrupt_pending,
  input wire logic i_interrupt_priority_active,
  input wire logic i_core_rmc,
  input wire logic i_serial_dma_req,
  input wire logic i_independent_dma_req,
  input wire logic i_independent_dma_ext_req,
  input wire logic i_card_req,
  output logic o_serial_dma_grant,
  output logic o_independent_dma_grant,
  output logic o_card_grant,
  output logic o_internal_bus_clear,
  input wire logic [2:0] i_irq_level,
  input wire logic i_avec_n,
  input wire logic i_rmc_pin_n,
  input wire logic i_chip_select0_n,
  output logic [2:0] o_shared_pin,
  output logic o_chip_select0_dtack_en,
  output logic [15:0] o_chip_select0_base,
  output logic o_vector_supply,
  output logic o_low_power,
  output logic [1:0] o_access_wait_states,
  output logic o_sync_access_mode,
  output logic o_cpu_disabled
);
  import bac_pkg::*;

  // Pin synchronisers: three stages, a change counts when stages two and three agree
  logic [`BAC_NPINS-1:0] pin_raw;
  logic [`BAC_NPINS-1:0] pin_s1_r;
  logic [`BAC_NPINS-1:0] pin_s2_r;
  logic [`BAC_NPINS-1:0] pin_s3_r;
  logic [`BAC_NPINS-1:0] pin_r;

  assign pin_raw = {i_cpu_disable_strap, i_bus_clear_out_n, i_bgack_n, i_halt_n,
                    i_berr_n, i_as_n, i_bg_n, i_br_n};

  always_ff @(posedge i_clk) begin
    pin_s1_r <= pin_raw;
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
  end

  // Filter runs through reset so the strap and halt pins are seen while reset is low
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < `BAC_NPINS; k++) begin
      if (pin_s2_r[k] == pin_s3_r[k]) begin
        pin_r[k] <= pin_s2_r[k];
      end
    end
  end

  logic br_low;
  logic bg_low;
  logic as_low;
  logic berr_low;
  logic halt_low;
  logic bgack_low;
  logic bus_clear_out_low;
  logic strap_now;

  assign br_low = !pin_r[`BAC_PIN_BR];
  assign bg_low = !pin_r[`BAC_PIN_BG];
  assign as_low = !pin_r[`BAC_PIN_AS];
  assign berr_low = !pin_r[`BAC_PIN_BERR];
  assign halt_low = !pin_r[`BAC_PIN_HALT];
  assign bgack_low = !pin_r[`BAC_PIN_BGACK];
  assign bus_clear_out_low = !pin_r[`BAC_PIN_BUS_CLEAR_OUT];
  assign strap_now = pin_r[`BAC_PIN_STRAP];

  // Strap caught by a clocked process while reset and halt are both asserted
  logic cpu_disabled_r;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n && halt_low) begin
      cpu_disabled_r <= strap_now;
    end else if (!i_reset_n) begin
      cpu_disabled_r <= 1'b0;
    end
  end

  // Control registers
  logic [`BAC_CTRL_W-1:0] ctrl_r;
  logic [15:0] cs0_base_r;
  logic ack_r;
  logic bus_clear_mask;
  logic lcs;
  logic sync_access_mode;
  logic external_master_wait;
  logic vector_gen_enable;
  logic low_power_enable;
  logic bus_clear_out_used;

  assign bus_clear_mask = ctrl_r[`BAC_CTRL_BUS_CLEAR_MASK];
  assign lcs = ctrl_r[`BAC_CTRL_LCS];
  assign sync_access_mode = ctrl_r[`BAC_CTRL_SAM];
  assign external_master_wait = ctrl_r[`BAC_CTRL_EXTERNAL_MASTER_WAIT];
  assign vector_gen_enable = ctrl_r[`BAC_CTRL_VGE];
  assign low_power_enable = ctrl_r[`BAC_CTRL_LOW_POWER_ENABLE];
  assign bus_clear_out_used = ctrl_r[`BAC_CTRL_BUS_CLEAR_OUT_USED];

  logic bus_req;
  logic wr_hit;

  assign bus_req = (i_avs_read || i_avs_write) && !ack_r;
  // Write lands at the edge where waitrequest is sampled low
  assign wr_hit = i_avs_write && ack_r;
  // One wait cycle per access; the answer comes on the second edge
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctrl_r <= `BAC_CTRL_RST;
    end else if (wr_hit && i_avs_address == `BAC_OFF_CTRL && i_avs_byteenable[0]) begin
      ctrl_r <= i_avs_writedata[`BAC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cs0_base_r <= cpu_disabled_r ? `BAC_CS0_BASE_DIS_RST : `BAC_CS0_BASE_CORE_RST;
    end else if (wr_hit && i_avs_address == `BAC_OFF_CS0_BASE) begin
      if (i_avs_byteenable[0]) begin
        cs0_base_r[7:0] <= i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[1]) begin
        cs0_base_r[15:8] <= i_avs_writedata[15:8];
      end
    end
  end

  // Arbitration state
  bac_state_t state_r;
  bac_owner_t owner_r;
  logic ipa_hold_r;
  logic bus_clear_out_assert;
  logic interrupt_pending_eff;

  // Interrupt pending counts only with the mask bit set
  assign interrupt_pending_eff = bus_clear_mask && i_interrupt_pending;

  // Holds the external clear until the priority-active bit drops
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ipa_hold_r <= 1'b0;
    end else begin
      ipa_hold_r <= interrupt_pending_eff || (ipa_hold_r && i_interrupt_priority_active);
    end
  end

  function automatic bac_owner_t bac_pick(input logic ext, input logic serial_dma,
                                          input logic independent_dma_int, input logic independent_dma_ext,
                                          input logic card, input logic interrupt_pending,
                                          input logic used);
    bac_owner_t w;
    w = BAC_OWN_NONE;
    if (ext && !used) begin
      w = BAC_OWN_EXT;
    end else if (serial_dma) begin
      w = BAC_OWN_SERIAL_DMA;
    end else if (independent_dma_ext) begin
      w = BAC_OWN_INDEPENDENT_DMA;
    end else if (interrupt_pending) begin
      w = BAC_OWN_NONE;
    end else if (independent_dma_int) begin
      w = BAC_OWN_INDEPENDENT_DMA;
    end else if (card) begin
      w = BAC_OWN_CARD;
    end else if (ext) begin
      w = BAC_OWN_EXT;
    end
    return w;
  endfunction : bac_pick

  logic independent_dma_int_req;
  logic independent_dma_ext_req;
  bac_owner_t pick_core;
  bac_owner_t pick_dis;

  assign independent_dma_int_req = i_independent_dma_req && !i_independent_dma_ext_req;
  assign independent_dma_ext_req = i_independent_dma_req && i_independent_dma_ext_req;
  assign pick_core = bac_pick(br_low, i_serial_dma_req, independent_dma_int_req, independent_dma_ext_req, i_card_req,
                              interrupt_pending_eff, bus_clear_out_used);
  assign pick_dis = bac_pick(1'b0, i_serial_dma_req, independent_dma_int_req, independent_dma_ext_req, i_card_req,
                             1'b0, 1'b0);

  logic bus_free;
  logic lock_hold;
  logic owner_req;

  assign bus_free = !as_low && !bgack_low;
  assign lock_hold = lcs && i_core_rmc;

  always_comb begin
    unique case (owner_r)
      BAC_OWN_EXT: owner_req = br_low;
      BAC_OWN_SERIAL_DMA: owner_req = i_serial_dma_req;
      BAC_OWN_INDEPENDENT_DMA: owner_req = i_independent_dma_req;
      BAC_OWN_CARD: owner_req = i_card_req;
      default: owner_req = 1'b0;
    endcase
  end

  // External master gave the bus back once its acknowledge was seen and released
  logic ext_seen_r;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ext_seen_r <= 1'b0;
    end else if (state_r != BAC_ST_OWNED) begin
      ext_seen_r <= 1'b0;
    end else if (bgack_low) begin
      ext_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r <= BAC_ST_IDLE;
      owner_r <= BAC_OWN_NONE;
    end else begin
      unique case (state_r)
        BAC_ST_IDLE: begin
          owner_r <= BAC_OWN_NONE;
          if (cpu_disabled_r && pick_dis != BAC_OWN_NONE) begin
            state_r <= BAC_ST_DIS_REQ;
          end else if (!cpu_disabled_r && pick_core != BAC_OWN_NONE) begin
            state_r <= BAC_ST_CORE_REQ;
          end
        end
        BAC_ST_CORE_REQ: begin
          if (pick_core == BAC_OWN_NONE) begin
            state_r <= BAC_ST_IDLE;
          end else if (i_core_bus_grant && !lock_hold) begin
            state_r <= BAC_ST_WAIT_FREE;
          end
        end
        BAC_ST_WAIT_FREE: begin
          if (pick_core == BAC_OWN_NONE) begin
            state_r <= BAC_ST_IDLE;
          end else if (bus_free) begin
            owner_r <= pick_core;
            state_r <= BAC_ST_OWNED;
          end
        end
        BAC_ST_OWNED: begin
          if (owner_r == BAC_OWN_EXT) begin
            if (ext_seen_r && !bgack_low) begin
              state_r <= BAC_ST_IDLE;
            end else if (!ext_seen_r && !br_low && !bgack_low) begin
              state_r <= BAC_ST_IDLE;
            end
          end else if (!owner_req) begin
            // Serial DMA drops its request after one operand
            state_r <= BAC_ST_IDLE;
          end
        end
        BAC_ST_DIS_REQ: begin
          if (pick_dis == BAC_OWN_NONE) begin
            state_r <= BAC_ST_IDLE;
          end else if (bg_low) begin
            state_r <= BAC_ST_DIS_WAIT;
          end
        end
        BAC_ST_DIS_WAIT: begin
          if (!as_low && !berr_low && !halt_low && !bgack_low) begin
            owner_r <= pick_dis;
            state_r <= (pick_dis == BAC_OWN_NONE) ? BAC_ST_IDLE : BAC_ST_DIS_OWN;
          end
        end
        BAC_ST_DIS_OWN: begin
          if (!owner_req) begin
            state_r <= BAC_ST_IDLE;
          end
        end
      endcase
    end
  end

  logic granted;

  assign granted = (state_r == BAC_ST_OWNED) || (state_r == BAC_ST_DIS_OWN);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_serial_dma_grant <= 1'b0;
      o_independent_dma_grant <= 1'b0;
      o_card_grant <= 1'b0;
    end else begin
      o_serial_dma_grant <= granted && owner_r == BAC_OWN_SERIAL_DMA;
      o_independent_dma_grant <= granted && owner_r == BAC_OWN_INDEPENDENT_DMA;
      o_card_grant <= granted && owner_r == BAC_OWN_CARD;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_core_bus_request <= 1'b0;
    end else begin
      o_core_bus_request <= !cpu_disabled_r && pick_core != BAC_OWN_NONE &&
                            (state_r == BAC_ST_IDLE || state_r == BAC_ST_CORE_REQ ||
                             state_r == BAC_ST_WAIT_FREE);
    end
  end

  // Request pin: input with core alive, driven for the DMAs and the card with core disabled
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_br_n <= 1'b1;
      o_br_oe <= 1'b0;
    end else begin
      o_br_oe <= cpu_disabled_r;
      o_br_n <= !(cpu_disabled_r && (state_r == BAC_ST_DIS_REQ || state_r == BAC_ST_DIS_WAIT));
    end
  end

  // Grant pin only answers the external master; internal DMA never touches it
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_bg_n <= 1'b1;
      o_bg_oe <= 1'b0;
    end else begin
      o_bg_oe <= !cpu_disabled_r;
      o_bg_n <= !(state_r == BAC_ST_OWNED && owner_r == BAC_OWN_EXT && br_low);
    end
  end

  // Acknowledge driven only while an internal master owns the bus
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_bgack_n <= 1'b1;
      o_bgack_oe <= 1'b0;
    end else begin
      o_bgack_oe <= granted && owner_r != BAC_OWN_EXT;
      o_bgack_n <= !(granted && owner_r != BAC_OWN_EXT);
    end
  end

  // Bus clear: no core interrupts exist with the core disabled
  assign bus_clear_out_assert = (i_serial_dma_req && !(granted && owner_r == BAC_OWN_INDEPENDENT_DMA)) ||
                       (!cpu_disabled_r && bus_clear_mask && ipa_hold_r);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_bus_clear_out_n <= 1'b1;
      o_bus_clear_out_oe <= 1'b0;
    end else begin
      o_bus_clear_out_n <= !bus_clear_out_assert;
      // Disabled core: pin shared, driven only while serial DMA asserts it
      o_bus_clear_out_oe <= cpu_disabled_r ? bus_clear_out_assert : 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_internal_bus_clear <= 1'b0;
    end else if (cpu_disabled_r) begin
      o_internal_bus_clear <= bus_clear_out_low || bus_clear_out_assert;
    end else begin
      o_internal_bus_clear <= br_low || (ipa_hold_r && bus_clear_mask && independent_dma_int_req);
    end
  end

  // Shared pins and mode-dependent outputs
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_shared_pin <= 3'h7;
    end else if (cpu_disabled_r) begin
      o_shared_pin <= i_irq_level;
    end else begin
      o_shared_pin <= {i_chip_select0_n, i_rmc_pin_n, i_avec_n};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_vector_supply <= 1'b0;
      o_low_power <= 1'b0;
      o_access_wait_states <= `BAC_ASYNC_WAIT;
      o_sync_access_mode <= 1'b0;
      o_chip_select0_dtack_en <= 1'b0;
      o_chip_select0_base <= `BAC_CS0_BASE_CORE_RST;
      o_cpu_disabled <= 1'b0;
    end else begin
      o_vector_supply <= !cpu_disabled_r || vector_gen_enable;
      o_low_power <= cpu_disabled_r && low_power_enable;
      o_access_wait_states <= !sync_access_mode ? `BAC_ASYNC_WAIT :
                              (external_master_wait ? `BAC_SYNC_WAIT_EXTRA : `BAC_SYNC_WAIT);
      o_sync_access_mode <= sync_access_mode;
      o_chip_select0_dtack_en <= 1'b1;
      o_chip_select0_base <= cs0_base_r;
      o_cpu_disabled <= cpu_disabled_r;
    end
  end

  // Read data, taken at the edge where waitrequest is still high, ready by the edge where it is low
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && !ack_r) begin
      unique case (i_avs_address)
        `BAC_OFF_CTRL: o_avs_readdata <= {25'h0, ctrl_r};
        `BAC_OFF_STATUS: o_avs_readdata <= {23'h0, state_r, ipa_hold_r,
                                            o_internal_bus_clear, bus_clear_out_assert,
                                            strap_now, cpu_disabled_r, granted};
        `BAC_OFF_CS0_BASE: o_avs_readdata <= {16'h0, cs0_base_r};
        default: o_avs_readdata <= 32'h0;
      endcase
    end
  end

endmodule : bac_arbiter

// [bac_arbiter_sva.sv]
// Port-level assertions for the bus arbiter
`timescale 1ns/1ps
module bac_arbiter_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_br_n,
  input wire logic o_br_oe,
  input wire logic i_bg_n,
  input wire logic i_as_n,
  input wire logic i_bgack_n,
  input wire logic o_bgack_n,
  input wire logic o_bgack_oe,
  input wire logic o_bus_clear_out_n,
  input wire logic o_core_bus_request,
  input wire logic i_core_bus_grant,
  input wire logic i_serial_dma_req,
  input wire logic o_serial_dma_grant,
  input wire logic o_independent_dma_grant,
  input wire logic o_card_grant,
  input wire logic o_internal_bus_clear,
  input wire logic [2:0] i_irq_level,
  input wire logic [2:0] o_shared_pin,
  input wire logic o_cpu_disabled
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  logic own;
  assign own = o_serial_dma_grant | o_independent_dma_grant | o_card_grant;
  sequence s_req_wait;
    (i_avs_read | i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_br_held;
    (!i_br_n && !o_cpu_disabled) [*2];
  endsequence
  property p_one_wait;
    s_req_wait |=> !o_avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("access waited too long");
  property p_single_owner;
    $onehot0({o_serial_dma_grant, o_independent_dma_grant, o_card_grant});
  endproperty
  a_single_owner: assert property (p_single_owner) else $error("two owners");
  property p_grant_after_cbg;
    $rose(own) && !o_cpu_disabled |-> $past(i_core_bus_grant);
  endproperty
  a_grant_after_cbg: assert property (p_grant_after_cbg) else $error("grant without core");
  property p_serial_first;
    $rose(o_independent_dma_grant) |-> !$past(i_serial_dma_req);
  endproperty
  a_serial_first: assert property (p_serial_first) else $error("serial outranked");
  property p_dma_bgack;
    (o_serial_dma_grant | o_independent_dma_grant) |-> ##[0:1] (o_bgack_oe && !o_bgack_n);
  endproperty
  a_dma_bgack: assert property (p_dma_bgack) else $error("owner not acknowledged");
  property p_br_core;
    $stable(o_cpu_disabled) && !o_cpu_disabled |-> !o_br_oe;
  endproperty
  a_br_core: assert property (p_br_core) else $error("request pin driven");
  property p_ack_idle;
    $fell(o_bgack_n) && o_cpu_disabled |-> $past(!i_bg_n && i_as_n && i_bgack_n);
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("acknowledge too early");
  property p_irq_out;
    (o_cpu_disabled && $stable(i_irq_level)) [*4] |-> o_shared_pin == i_irq_level;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("level pins wrong");
  property p_internal_bus_clear_br;
    s_br_held |-> ##[0:6] o_internal_bus_clear;
  endproperty
  a_internal_bus_clear_br: assert property (p_internal_bus_clear_br) else $error("no internal clear");
  property p_clr_serial;
    (i_serial_dma_req && !o_independent_dma_grant && !o_cpu_disabled) [*2] |-> ##[0:4] !o_bus_clear_out_n;
  endproperty
  a_clr_serial: assert property (p_clr_serial) else $error("no bus clear");
  property p_reset_clear;
    $rose(i_reset_n) |-> !own && !o_core_bus_request;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("grant after reset");
endmodule : bac_arbiter_chk
bind bac_arbiter bac_arbiter_chk u_chk (.*);

// [bac_host_model.sv]
// External master or host processor on the arbitration pins
`timescale 1ns/1ps
module bac_host_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_disabled,
  input wire logic i_want,
  input wire logic [3:0] i_delay,
  input wire logic i_br_n,
  input wire logic i_bg_n,
  input wire logic i_bgack_n,
  output logic o_br_low,
  output logic o_bg_low,
  output logic o_bgack_low,
  output logic o_as_n
);
  logic [3:0] cnt_r;
  logic owned_r;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_br_low <= 1'b0;
      o_bg_low <= 1'b0;
      o_bgack_low <= 1'b0;
      o_as_n <= 1'b1;
      owned_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (i_disabled) begin
      if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      else
        o_as_n <= 1'b1;
      // Grant while own cycle still runs, so the device must wait
      if (!i_br_n && !o_bg_low && i_bgack_n) begin
        o_bg_low <= 1'b1;
        o_as_n <= 1'b0;
        cnt_r <= i_delay;
      end
      if (!i_bgack_n)
        o_bg_low <= 1'b0;
    end else begin
      if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      // Model carries no function code, so the all-ones code never appears
      o_as_n <= !(owned_r && cnt_r != 4'h0);
      if (i_want && !owned_r && !o_br_low)
        o_br_low <= 1'b1;
      if (o_br_low && !i_bg_n && o_as_n && i_bgack_n) begin
        o_bgack_low <= 1'b1;
        o_br_low <= 1'b0;
        owned_r <= 1'b1;
        cnt_r <= 4'h3;
      end
      if (owned_r && !i_want && cnt_r == 4'h0) begin
        o_bgack_low <= 1'b0;
        owned_r <= 1'b0;
      end
    end
  end
endmodule : bac_host_model

// [bac_arbiter_bench.sv]
// Self-checking bench for the bus arbiter
`timescale 1ns/1ps
module bac_arbiter_bench;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic i_cpu_disable_strap = 1'b0, i_halt_n = 1'b0, i_core_bus_grant = 1'b0;
  logic i_interrupt_pending = 1'b0, i_interrupt_priority_active = 1'b0, i_core_rmc = 1'b0;
  logic i_serial_dma_req = 1'b0, i_independent_dma_req = 1'b0, i_independent_dma_ext_req = 1'b0, i_card_req = 1'b0;
  logic i_berr_n = 1'b1, i_avec_n = 1'b1, i_rmc_pin_n = 1'b1, i_chip_select0_n = 1'b1;
  logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hf, dly = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
  logic [2:0] i_irq_level = 3'h2, o_shared_pin;
  logic [15:0] o_chip_select0_base;
  logic [1:0] o_access_wait_states;
  logic o_avs_waitrequest, o_br_n, o_br_oe, o_bg_n, o_bg_oe, o_bgack_n, o_bgack_oe;
  logic o_bus_clear_out_n, o_bus_clear_out_oe, o_core_bus_request, o_serial_dma_grant;
  logic o_independent_dma_grant, o_card_grant, o_internal_bus_clear, o_chip_select0_dtack_en;
  logic o_vector_supply, o_low_power, o_sync_access_mode, o_cpu_disabled;
  logic want = 1'b0, clr_low = 1'b0, h_br, h_bg, h_ack, i_as_n;
  wire logic i_br_n, i_bg_n, i_bgack_n, i_bus_clear_out_n;
  logic [3:0] wcfg [3] = '{4'h0, 4'h4, 4'hc};
  logic [1:0] wexp [3] = '{2'h3, 2'h0, 2'h1};
  int miscompares = 0, n_checks = 0;
  logic [12:0] obs;
  // Pulled-up pins: low while any party drives low
  assign i_br_n = !((o_br_oe & !o_br_n) | h_br);
  assign i_bg_n = !((o_bg_oe & !o_bg_n) | h_bg);
  assign i_bgack_n = !((o_bgack_oe & !o_bgack_n) | h_ack);
  assign i_bus_clear_out_n = !((o_bus_clear_out_oe & !o_bus_clear_out_n) | clr_low);
  assign obs = {o_chip_select0_dtack_en, o_cpu_disabled, o_vector_supply, o_low_power,
    i_bgack_n, i_bg_n, i_br_n, i_bus_clear_out_n, o_internal_bus_clear,
    o_core_bus_request, o_card_grant, o_independent_dma_grant, o_serial_dma_grant};
  bac_arbiter dut (.*);
  bac_host_model host (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_disabled(o_cpu_disabled),
    .i_want(want), .i_delay(dly), .i_br_n(i_br_n), .i_bg_n(i_bg_n), .i_bgack_n(i_bgack_n),
    .o_br_low(h_br), .o_bg_low(h_bg), .o_bgack_low(h_ack), .o_as_n(i_as_n));
  always #5 i_clk = ~i_clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Sample on the falling edge, hand back on a rising one
  task automatic wt(input int b, input logic v, input string nm);
    for (int k = 0; k < 60 && obs[b] !== v; k++)
      @(negedge i_clk);
    chk(nm, {31'h0, obs[b]}, {31'h0, v});
    @(posedge i_clk);
  endtask : wt
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    for (int k = 0; k < 50; k++) begin
      @(posedge i_clk);
      if (o_avs_waitrequest === 1'b0)
        break;
    end
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : acc
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wreg
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask : rchk
  // Halt stays low so the strap is caught
  task automatic rst(input logic s);
    @(posedge i_clk);
    i_halt_n <= 1'b0;
    i_cpu_disable_strap <= s;
    // Pins need their synchroniser delay before reset samples them
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    i_halt_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask : rst
  initial begin
    rst(1'b0);
    wt(3, 1'b0, "core request idle");
    rchk(4'h0, 32'h0, "control reset");
    rchk(4'hc, 32'h0, "unmapped");
    foreach (wcfg[k]) begin
      wreg(4'h0, {28'h0, wcfg[k]});
      rchk(4'h0, {28'h0, wcfg[k]}, "control");
      chk("wait states", {30'h0, o_access_wait_states}, {30'h0, wexp[k]});
    end
    i_serial_dma_req <= 1'b1;
    i_independent_dma_req <= 1'b1;
    i_card_req <= 1'b1;
    wt(3, 1'b1, "core request");
    wt(5, 1'b0, "bus clear serial");
    chk("early grant", {29'h0, obs[2:0]}, 32'h0);
    i_core_bus_grant <= 1'b1;
    wt(0, 1'b1, "serial grant");
    i_serial_dma_req <= 1'b0;
    wt(1, 1'b1, "independent grant");
    i_independent_dma_req <= 1'b0;
    wt(2, 1'b1, "card grant");
    i_card_req <= 1'b0;
    wt(2, 1'b0, "card release");
    want <= 1'b1;
    wt(7, 1'b0, "external grant");
    i_serial_dma_req <= 1'b1;
    wt(8, 1'b0, "external acknowledge");
    chk("serial under external", {31'h0, obs[0]}, 32'h0);
    want <= 1'b0;
    wt(0, 1'b1, "serial after external");
    i_serial_dma_req <= 1'b0;
    wt(0, 1'b0, "serial release");
    wreg(4'h0, 32'h2);
    i_core_rmc <= 1'b1;
    i_card_req <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk("locked hold", {31'h0, obs[2]}, 32'h0);
    i_core_rmc <= 1'b0;
    wt(2, 1'b1, "locked done");
    i_card_req <= 1'b0;
    wt(2, 1'b0, "card off");
    i_core_bus_grant <= 1'b0;
    wreg(4'h0, 32'h1);
    i_interrupt_pending <= 1'b1;
    i_interrupt_priority_active <= 1'b1;
    i_independent_dma_req <= 1'b1;
    wt(4, 1'b1, "clear on interrupt");
    wt(5, 1'b0, "bus clear interrupt");
    i_interrupt_pending <= 1'b0;
    i_independent_dma_req <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk("bus clear held", {31'h0, obs[5]}, 32'h0);
    i_interrupt_priority_active <= 1'b0;
    wt(5, 1'b1, "bus clear off");
    rst(1'b1);
    rchk(4'h8, 32'hc000, "base reset");
    wt(11, 1'b1, "core disabled");
    wt(12, 1'b1, "acknowledge enable");
    i_irq_level <= 3'h6;
    repeat (5) @(posedge i_clk);
    chk("level pins", {29'h0, o_shared_pin}, 32'h6);
    for (int k = 0; k < 2; k++) begin
      dly <= (k == 0) ? 4'h0 : 4'h5;
      i_independent_dma_ext_req <= k[0];
      i_independent_dma_req <= 1'b1;
      wt(6, 1'b0, "bus request out");
      wt(8, 1'b0, "acknowledge out");
      chk("independent owner", {31'h0, obs[1]}, 32'h1);
      i_independent_dma_req <= 1'b0;
      wt(8, 1'b1, "acknowledge off");
    end
    clr_low <= 1'b1;
    wt(4, 1'b1, "clear from pin");
    clr_low <= 1'b0;
    wt(4, 1'b0, "clear pin off");
    for (int k = 0; k < 2; k++) begin
      wreg(4'h0, 32'h10 << k);
      wt(10 - k, 1'b1, "mode bit on");
      wreg(4'h0, 32'h0);
      wt(10 - k, 1'b0, "mode bit off");
    end
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    end_sim();
  end
endmodule : bac_arbiter_bench
